// [src/general_output_pin_three_mux_cfg.svh]
/*
  constants for the third general output source selector.
  assumes inclusion by bare name from the design file.
*/
`ifndef OUT_THREE_MUX_CFG_SVH
`define OUT_THREE_MUX_CFG_SVH
`define OUT3_CTRL_ADDR   8'h1d
`define OUT3_SEL_RESET   4'h0
`define OUT3_SEL_MSB     3
`define OUT3_UPPER_ZERO  4'h0
`define OUT3_READ_IDLE   8'h00
`define OUT3_PIN_RESET   1'h0
`endif

// [src/general_output_pin_three_mux_pkg.sv]
/*
  types for the third general output source selector.
  assumes the cfg header for numeric constants.
*/
package out_three_mux_pkg;
  typedef enum logic [3:0] {
    SEL_LOW, SEL_HIGH, SEL_RATE_IRQ, SEL_TX_IRQ, SEL_RX_IRQ, SEL_PREEMPH,
    SEL_NON_AUDIO, SEL_NON_VALID, SEL_CHAN_STATUS, SEL_USER_BIT, SEL_BLOCK_START,
    SEL_COPY_BIT, SEL_GEN_BIT, SEL_PARITY_ERR, SEL_RX_SYNC, SEL_TX_SYNC
  } out_sel_t;

  // routed signals, all from other clock domains or pins
  typedef struct packed {
    logic rate_converter_irq_n;
    logic tx_irq_n;
    logic rx_irq_n;
    logic rx_preemph;
    logic rx_non_audio;
    logic rx_non_valid;
    logic rx_chan_status;
    logic rx_user_bit;
    logic rx_block_start;
    logic rx_copy_bit;
    logic rx_gen_bit;
    logic rx_parity_err;
    logic rx_sync_clk;
    logic tx_sync_clk;
  } source_bus_t;
endpackage : out_three_mux_pkg

// [src/general_output_three_source_mux.sv]
/*
  source selector for general output pin three, with its control register.
  assumes a plain register port on core_clk and asynchronous source signals.
*/
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "general_output_pin_three_mux_cfg.svh"

module general_output_three_source_mux
  import out_three_mux_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic  [7:0] reg_addr,
  input  wire logic  [7:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic       [7:0] reg_rdata,
  input  wire source_bus_t source_in,
  output logic             general_output_pin_three
);

  // three-stage sampling; a change counts once stages two and three agree
  source_bus_t sync1_q;
  source_bus_t sync2_q;
  source_bus_t sync3_q;
  source_bus_t stable_q;
  source_bus_t stable_d;
  out_sel_t    out_three_source_select_q;
  logic        pin_d;
  logic        hit;

  // address decode for the only mapped register
  assign hit = (reg_addr == `OUT3_CTRL_ADDR);
  // stable value only moves when the two late stages match, filtering runts
  assign stable_d = source_bus_t'((sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q)));

  // sync stages carry no reset; only the filtered copy needs a known start
  always_ff @(posedge core_clk) begin
    sync1_q  <= source_in;
    sync2_q  <= sync1_q;
    sync3_q  <= sync2_q;
    stable_q <= srst ? source_bus_t'('0) : stable_d;
  end

  // control register; upper nibble of the write is dropped
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_three_source_select_q <= out_sel_t'(`OUT3_SEL_RESET);
    end else if (reg_wr && hit) begin
      out_three_source_select_q <= out_sel_t'(reg_wdata[`OUT3_SEL_MSB:0]);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= `OUT3_READ_IDLE;
    end else if (reg_rd && hit) begin
      reg_rdata <= {`OUT3_UPPER_ZERO, out_three_source_select_q};
    end else begin
      reg_rdata <= `OUT3_READ_IDLE;
    end
  end

  // source selection; registered pin so a select change never glitches it
  always_comb begin
    case (out_three_source_select_q)
      SEL_LOW:         pin_d = 1'h0;
      SEL_HIGH:        pin_d = 1'h1;
      SEL_RATE_IRQ:    pin_d = stable_q.rate_converter_irq_n;
      SEL_TX_IRQ:      pin_d = stable_q.tx_irq_n;
      SEL_RX_IRQ:      pin_d = stable_q.rx_irq_n;
      SEL_PREEMPH:     pin_d = ~stable_q.rx_preemph;
      SEL_NON_AUDIO:   pin_d = stable_q.rx_non_audio;
      SEL_NON_VALID:   pin_d = stable_q.rx_non_valid;
      SEL_CHAN_STATUS: pin_d = stable_q.rx_chan_status;
      SEL_USER_BIT:    pin_d = stable_q.rx_user_bit;
      SEL_BLOCK_START: pin_d = stable_q.rx_block_start;
      SEL_COPY_BIT:    pin_d = stable_q.rx_copy_bit;
      SEL_GEN_BIT:     pin_d = stable_q.rx_gen_bit;
      SEL_PARITY_ERR:  pin_d = stable_q.rx_parity_err;
      SEL_RX_SYNC:     pin_d = stable_q.rx_sync_clk;
      SEL_TX_SYNC:     pin_d = stable_q.tx_sync_clk;
      default:         pin_d = 1'h0;
    endcase
  end

  // pin flop; costs one cycle of latency but the pin never sees a decode glitch
  always_ff @(posedge core_clk) begin
    general_output_pin_three <= srst ? `OUT3_PIN_RESET : pin_d;
  end

  // reset and fixed levels
  chk_reset_low_pin: assert property (@(posedge core_clk)
    srst |=> !general_output_pin_three)
    else $error("pin not low after reset");

  chk_forced_high: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_HIGH |=> general_output_pin_three)
    else $error("forced high not driven");

  chk_forced_low: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_LOW |=> !general_output_pin_three)
    else $error("forced low not driven");

  // register port
  chk_write_takes: assert property (@(posedge core_clk) disable iff (srst)
    reg_wr && hit
    |=> out_three_source_select_q == $past(reg_wdata[`OUT3_SEL_MSB:0]))
    else $error("selector write lost");

  chk_select_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_wr && hit)
    |=> out_three_source_select_q == $past(out_three_source_select_q))
    else $error("selector changed without a write");

  chk_read_upper: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd && hit
    |=> reg_rdata == {`OUT3_UPPER_ZERO, $past(out_three_source_select_q)})
    else $error("read value wrong");

  chk_read_idle: assert property (@(posedge core_clk) disable iff (srst)
    !(reg_rd && hit)
    |=> reg_rdata == `OUT3_READ_IDLE)
    else $error("read data not idle");

  // input filter; a runt shorter than two cycles never reaches the mux
  chk_stable_reset: assert property (@(posedge core_clk)
    srst |=> stable_q == source_bus_t'('0))
    else $error("filtered sources not cleared by reset");

  chk_filter_take: assert property (@(posedge core_clk) disable iff (srst)
    sync2_q == sync3_q
    |=> stable_q == $past(sync3_q))
    else $error("agreed source value not taken");

  chk_filter_hold: assert property (@(posedge core_clk) disable iff (srst)
    1'h1
    |=> ((stable_q ^ $past(stable_q)) & $past(sync2_q ^ sync3_q)) == '0)
    else $error("source bit moved while stages disagreed");

  // routed sources
  chk_preemph_inv: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_PREEMPH
    |=> general_output_pin_three == !$past(stable_q.rx_preemph))
    else $error("pre-emphasis polarity wrong");

  chk_rate_irq: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_RATE_IRQ
    |=> general_output_pin_three == $past(stable_q.rate_converter_irq_n))
    else $error("rate irq not routed");

  chk_tx_irq: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_TX_IRQ
    |=> general_output_pin_three == $past(stable_q.tx_irq_n))
    else $error("tx irq not routed");

  chk_rx_irq: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_RX_IRQ
    |=> general_output_pin_three == $past(stable_q.rx_irq_n))
    else $error("rx irq not routed");

  chk_non_audio: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_NON_AUDIO
    |=> general_output_pin_three == $past(stable_q.rx_non_audio))
    else $error("non-audio not routed");

  chk_non_valid: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_NON_VALID
    |=> general_output_pin_three == $past(stable_q.rx_non_valid))
    else $error("non-valid not routed");

  chk_chan_status: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_CHAN_STATUS
    |=> general_output_pin_three == $past(stable_q.rx_chan_status))
    else $error("channel status not routed");

  chk_user_bit: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_USER_BIT
    |=> general_output_pin_three == $past(stable_q.rx_user_bit))
    else $error("user bit not routed");

  chk_block_start: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_BLOCK_START
    |=> general_output_pin_three == $past(stable_q.rx_block_start))
    else $error("block start not routed");

  chk_copy_bit: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_COPY_BIT
    |=> general_output_pin_three == $past(stable_q.rx_copy_bit))
    else $error("copy bit not routed");

  chk_gen_bit: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_GEN_BIT
    |=> general_output_pin_three == $past(stable_q.rx_gen_bit))
    else $error("generation bit not routed");

  chk_parity_err: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_PARITY_ERR
    |=> general_output_pin_three == $past(stable_q.rx_parity_err))
    else $error("parity error not routed");

  chk_rx_sync: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_RX_SYNC
    |=> general_output_pin_three == $past(stable_q.rx_sync_clk))
    else $error("rx sync not routed");

  chk_tx_sync: assert property (@(posedge core_clk) disable iff (srst)
    out_three_source_select_q == SEL_TX_SYNC
    |=> general_output_pin_three == $past(stable_q.tx_sync_clk))
    else $error("tx sync not routed");

endmodule : general_output_three_source_mux

// [tb/pin_observer.sv]
/* partner: logic that watches output pin three.
   assumes core_clk comes from the bench. */
`timescale 1ns/100ps
// one receiving flop, on the same core_clk that drives the pin
module pin_observer (
  input  wire logic core_clk,
  input  wire logic pin_in,
  output logic      seen_q
);
  always_ff @(posedge core_clk) begin
    seen_q <= pin_in;
  end
endmodule : pin_observer

// [tb/tb_top.sv]
/* bench for the output three source selector, with a reference model.
   assumes the design and the pin observer sample on core_clk. */
`timescale 1ns/100ps
`include "general_output_pin_three_mux_cfg.svh"
module tb_top
  import out_three_mux_pkg::*;
;
  logic        core_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pin, seen_q;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [13:0] source_v = 14'h0000;
  int          mismatches = 0, samples_checked = 0, sel_m = 0;

  always #5 core_clk = ~core_clk;
  general_output_three_source_mux dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .source_in(source_v), .general_output_pin_three(pin));
  pin_observer obs_u (.core_clk(core_clk), .pin_in(pin), .seen_q(seen_q));

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch data t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_data
  task automatic cmp_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch pin t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin
  // one-cycle strobes; the model register follows only the mapped address
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    if (a == `OUT3_CTRL_ADDR) sel_m = d[3:0];
  endtask : bus_wr
  // read data stand only in the cycle after the strobe, so look right then
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 cmp_data(reg_rdata, exp);
  endtask : bus_rd
  // codes 2..15 map to source bits from the top down; code 5 is inverted
  function automatic logic exp_pin(input int s, input logic [13:0] v);
    if (s < 2) return s[0];
    return (s == 5) ^ v[15 - s];
  endfunction : exp_pin
  // eight cycles cover the synchroniser, the pin flop and the observer
  task automatic check_pin();
    repeat (8) @(posedge core_clk);
    #1 cmp_pin(seen_q, exp_pin(sel_m, source_v));
  endtask : check_pin

  // main sequence
  initial begin
    void'($urandom(72409));
    repeat (6) @(posedge core_clk);
    srst <= 1'h0;
    bus_rd(`OUT3_CTRL_ADDR, 8'h00);
    check_pin();
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      bus_wr(`OUT3_CTRL_ADDR, {4'($urandom), 4'(c)});
      bus_rd(`OUT3_CTRL_ADDR, {`OUT3_UPPER_ZERO, 4'(c)});
      // second pass inverts every source so each code from 2 up sees both pin levels
      for (int k = 0; k < 2; k++) begin
        source_v <= (k == 0) ? 14'($urandom) : ~source_v;
        check_pin();
      end
    end
    $display("test codes done");
    bus_wr(8'h1e, 8'h01);
    bus_rd(8'h1e, `OUT3_READ_IDLE);
    bus_rd(`OUT3_CTRL_ADDR, {`OUT3_UPPER_ZERO, 4'(sel_m)});
    $display("test unmapped done");
    // a one-cycle runt on the routed irq must never reach the pin
    bus_wr(`OUT3_CTRL_ADDR, 8'h02);
    source_v <= 14'h0000;
    check_pin();
    source_v <= 14'h2000;
    @(posedge core_clk);
    source_v <= 14'h0000;
    repeat (8) begin
      @(posedge core_clk);
      #1 cmp_pin(seen_q, exp_pin(sel_m, source_v));
    end
    $display("test runt filter done");
    srst <= 1'h1;
    sel_m = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'h0;
    bus_rd(`OUT3_CTRL_ADDR, 8'h00);
    check_pin();
    $display("test mid reset done");
    end_of_test();
  end
  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb_top
